// ### core/rff_rx_fifo_flag.sv
`timescale 1ns/1ps
`default_nettype none
module rff_rx_fifo_flag
  import rff_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic wr_ready_out,
  input wire logic rd_en_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic rd_empty_out,
  input wire logic [7:0] fifo_byte_count_in,
  input wire logic fifo_rx_idle_enable_in,
  input wire logic rx_idle_8bit_in,
  input wire logic flag_clear_in,
  output logic rx_data_full_flag_out,
  output logic [CNT_W-1:0] fill_count_out
);

  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr_q;
  logic [PTR_W-1:0] rptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic flag_q;
  logic flag_d;
  logic miss_q;
  logic miss_d;

  wire full_w = (cnt_q == CNT_W'(FIFO_DEPTH));
  wire empty_w = (cnt_q == CNT_ZERO);
  wire do_wr = wr_valid_in && !full_w;
  wire do_rd = rd_en_in && !empty_w;
  wire [CNT_W-1:0] thr_w = fifo_byte_count_in[CNT_W-1:0];
  wire thr_ok_w = (fifo_byte_count_in[BYTE_COUNT_W-1:CNT_W] == BYTE_HIGH_ZERO) &&
                  (thr_w != CNT_ZERO);
  wire coin_w = do_wr && do_rd;
  // with a setting of two or more a coincident access at threshold still fires
  wire coin_hit_w = coin_w && (thr_w >= CNT_TWO) && (cnt_q == thr_w);
  wire hit_w = thr_ok_w && (cnt_d == thr_w) && ((cnt_q != thr_w) || coin_hit_w);
  // the coincident-access case with a setting of 1 misses the threshold
  wire miss_case_w = do_wr && do_rd && (thr_w == CNT_ONE) && (cnt_q == CNT_ONE);
  wire late_w = miss_q && ((do_wr && !do_rd) ||
                (fifo_rx_idle_enable_in && rx_idle_8bit_in));

  assign wr_ready_out = !full_w;
  assign rd_empty_out = empty_w;
  assign rd_data_out = mem_q[rptr_q];
  assign rx_data_full_flag_out = flag_q;
  assign fill_count_out = cnt_q;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (do_wr && !do_rd) begin
      cnt_d = cnt_q + CNT_ONE;
    end else if (do_rd && !do_wr) begin
      cnt_d = cnt_q - CNT_ONE;
    end
    miss_d = miss_q;
    if (miss_case_w) begin
      miss_d = 1'b1;
    end else if (late_w || empty_w) begin
      miss_d = 1'b0;
    end
    flag_d = flag_q;
    if (flag_clear_in) begin
      flag_d = 1'b0;
    end
    if (hit_w || late_w) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wptr_q <= PTR_ZERO;
      rptr_q <= PTR_ZERO;
      cnt_q <= CNT_ZERO;
      flag_q <= 1'b0;
      miss_q <= 1'b0;
    end else begin
      if (do_wr) begin
        wptr_q <= wptr_q + PTR_ONE;
      end
      if (do_rd) begin
        rptr_q <= rptr_q + PTR_ONE;
      end
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      miss_q <= miss_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_q[wptr_q] <= wr_data_in;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_HIT_SETS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    hit_w |=> rx_data_full_flag_out)
    else $error("threshold reached but flag not set");

  AST_MISS_NOFLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (miss_case_w && !flag_q && !late_w) |=> !rx_data_full_flag_out)
    else $error("missed case set flag");

  AST_THR2_NORMAL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (thr_ok_w && thr_w >= CNT_TWO && cnt_d == thr_w && cnt_q != thr_w) |=> flag_q)
    else $error("flag not raised at threshold two or more");

  AST_LATE_WORD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (miss_q && do_wr && !do_rd) |=> (flag_q && !miss_q))
    else $error("late flag on next word missing");

  AST_LATE_IDLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (miss_q && fifo_rx_idle_enable_in && rx_idle_8bit_in) |=> flag_q)
    else $error("late flag on idle missing");

  AST_CNT_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (do_wr && do_rd) |=> $stable(fill_count_out))
    else $error("count changed on coincident access");

  AST_CNT_INC: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (do_wr && !do_rd) |=> (fill_count_out == $past(fill_count_out) + CNT_ONE))
    else $error("count did not increment");

  AST_NO_IDLE_WITHOUT_EN: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!flag_q && !hit_w && !late_w) |=> !flag_q)
    else $error("flag set without cause");

  // ------------------------------------------------------------
  // reset, count and storage checks
  // ------------------------------------------------------------
  AST_RESET_CLEARS: assert property (@(posedge clk_sys_in) rst_in |=>
    (fill_count_out == CNT_ZERO && !rx_data_full_flag_out && rd_empty_out && wr_ready_out))
    else $error("reset left state behind");

  AST_CNT_DEC: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (do_rd && !do_wr) |=> (fill_count_out == $past(fill_count_out) - CNT_ONE))
    else $error("count did not decrement");

  AST_CNT_IDLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!do_wr && !do_rd) |=> $stable(fill_count_out))
    else $error("count changed without access");

  AST_FULL_REFUSES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_valid_in && !wr_ready_out && !rd_en_in) |=> $stable(fill_count_out))
    else $error("write taken while full");

  AST_EMPTY_REFUSES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rd_en_in && rd_empty_out && !wr_valid_in) |=> $stable(fill_count_out))
    else $error("read taken while empty");

  AST_CNT_RANGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (fill_count_out <= CNT_W'(FIFO_DEPTH)))
    else $error("count beyond depth");

  AST_WRITE_STORED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (do_wr && empty_w) |=> (rd_data_out == $past(wr_data_in)))
    else $error("word written to empty fifo not at head");

  AST_PTR_GAP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ((wptr_q - rptr_q) == cnt_q[PTR_W-1:0]))
    else $error("pointer gap differs from count");

  // ------------------------------------------------------------
  // flag checks
  // ------------------------------------------------------------
  AST_CLEAR_DROPS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (flag_clear_in && !hit_w && !late_w) |=> !rx_data_full_flag_out)
    else $error("clear did not drop flag");

  AST_SET_BEATS_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (flag_clear_in && (hit_w || late_w)) |=> rx_data_full_flag_out)
    else $error("clear beat a set event");

  AST_FLAG_HOLDS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (flag_q && !flag_clear_in) |=> flag_q)
    else $error("flag dropped without clear");

  AST_MISS_ARMS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    miss_case_w |=> miss_q)
    else $error("missed threshold not remembered");

  AST_NO_MISS_THR2: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!miss_q && thr_w != CNT_ONE) |=> !miss_q)
    else $error("miss armed with setting other than one");

  AST_THR2_COINCIDENT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (coin_w && thr_ok_w && thr_w >= CNT_TWO && cnt_q == thr_w) |=> flag_q)
    else $error("coincident access at threshold two or more did not set flag");

  AST_LATE_IDLE_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (miss_q && fifo_rx_idle_enable_in && rx_idle_8bit_in && !miss_case_w) |=> !miss_q)
    else $error("miss not cleared by idle");

  AST_IDLE_GATED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!flag_q && miss_q && !fifo_rx_idle_enable_in && !do_wr && !hit_w) |=> !flag_q)
    else $error("idle set flag while idle enable off");

  AST_MISS_EMPTY_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (miss_q && rd_empty_out) |=> !miss_q)
    else $error("miss kept with empty fifo");

  AST_OFF_NEVER_FIRES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!thr_ok_w && !flag_q && !late_w) |=> !flag_q)
    else $error("flag set with threshold out of range");

endmodule
`default_nettype wire

// ### core/rff_pkg.sv
`default_nettype none
package rff_pkg;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int DATA_W = 9;
  localparam int PTR_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam int BYTE_COUNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_TWO = 5'h02;
  localparam logic [BYTE_COUNT_W-CNT_W-1:0] BYTE_HIGH_ZERO = 3'h0;
endpackage
`default_nettype wire

// ### verification/rff_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// receiver front end: numbers its words, next word shown after each accepted write
module rff_rx_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  input wire logic wr_ready_in,
  output logic [8:0] wr_data_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) wr_data_out <= 9'h000;
    else if (wr_valid_in && wr_ready_in) wr_data_out <= wr_data_out + 9'h001;
  end
endmodule
`default_nettype wire

// ### verification/serial_rx_fifo_full_flag_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_rx_fifo_full_flag_tb_top;
  import rff_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wv = 1'b0, rd = 1'b0, en = 1'b1, idl = 1'b0, clr = 1'b0;
  logic [7:0] thr = 8'h02;
  logic [DATA_W-1:0] wd, rdat;
  logic flag, ety, rdy;
  logic [CNT_W-1:0] cnt;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  initial forever #4 clk = ~clk;
  rff_rx_model i_rx (.clk_in(clk), .rst_in(rst), .wr_valid_in(wv), .wr_ready_in(rdy),
    .wr_data_out(wd));
  rff_rx_fifo_flag i_dut (.clk_sys_in(clk), .rst_in(rst), .wr_valid_in(wv), .wr_data_in(wd),
    .wr_ready_out(rdy), .rd_en_in(rd), .rd_data_out(rdat), .rd_empty_out(ety),
    .fifo_byte_count_in(thr), .fifo_rx_idle_enable_in(en), .rx_idle_8bit_in(idl),
    .flag_clear_in(clr), .rx_data_full_flag_out(flag), .fill_count_out(cnt));
  task automatic wrap_up;
    $display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one cycle of write, read, idle, clear
  task automatic step(input logic [3:0] v);
    {wv, rd, idl, clr} = v;
    @(negedge clk);
  endtask
  task automatic rst6(input logic [7:0] t);
    {rst, thr} = {1'b1, t};
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic t_thr2;
    step(4'h8);
    chk(flag, 1'b0);
    step(4'hc);
    chk(cnt, 5'h01);
    step(4'h8);
    step(4'h0);
    chk(flag, 1'b1);
    step(4'h1);
    chk(flag, 1'b0);
    step(4'hc);
    step(4'h0);
    chk(flag, 1'b1);
    chk(cnt, 5'h02);
  endtask
  task automatic t_miss;
    step(4'h8);
    chk(flag, 1'b1);
    step(4'h1);
    step(4'hc);
    chk(flag, 1'b0);
    chk(rdat, 9'h001);
    step(4'h8);
    step(4'h0);
    chk(flag, 1'b1);
  endtask
  task automatic t_idle;
    {en, thr} = {1'b0, 8'h01};
    step(4'h8);
    step(4'h1);
    step(4'hc);
    step(4'h2);
    chk(flag, 1'b0);
    en = 1'b1;
    step(4'h2);
    step(4'h0);
    chk(flag, 1'b1);
  endtask
  task automatic t_full;
    step(4'h4);
    chk(cnt, 5'h00);
    repeat (15) step(4'h8);
    chk(flag, 1'b0);
    chk(rdy, 1'b1);
    step(4'h8);
    chk(flag, 1'b1);
    chk(rdy, 1'b0);
    step(4'h8);
    chk(cnt, 5'h10);
    chk(rdat, 9'h000);
    step(4'h4);
    chk(cnt, 5'h0f);
    chk(rdat, 9'h001);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    rst6(8'h02);
    chk(ety, 1'b1);
    t_thr2();
    rst6(8'h01);
    t_miss();
    rst6(8'h01);
    t_idle();
    rst6(8'h10);
    t_full();
    wrap_up();
  end
endmodule
`default_nettype wire
